// >>> bench/rcsr_radio_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcsr_radio_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] lvl_i,
  input wire logic pkt_i,
  input wire logic crc_err_i,
  input wire logic fec_err_i,
  input wire logic [10:0] busy_i,
  output rcsr_pkg::rcsr_radio_in_t radio_o
);
  import rcsr_pkg::*;

  // Datapath levels follow the bench one cycle later
  always @(posedge clk_i) begin
    if (rst_i) begin
      radio_o <= '0;
    end else begin
      {radio_o.chip_enable, radio_o.xtal_running, radio_o.carrier_above} <= lvl_i[6:4];
      {radio_o.csma_fail, radio_o.cca_fail, radio_o.fifo_margin} <= lvl_i[3:1];
      radio_o.frame_pending <= lvl_i[0];
      radio_o.src_busy <= busy_i;
      radio_o.pkt_valid <= pkt_i;
      // Error lines toggle outside a packet so stale values never look valid
      radio_o.pkt_crc_err <= pkt_i ? crc_err_i : ~radio_o.pkt_crc_err;
      radio_o.pkt_fec_err <= pkt_i ? fec_err_i : ~radio_o.pkt_fec_err;
    end
  end
endmodule
`default_nettype wire

// >>> bench/test_radio_control_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_radio_control_status_regs;
  import rcsr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat_o;
  logic ack;
  logic [6:0] lvl = 7'h0;
  logic [10:0] busy = 11'h0;
  logic pkt = 1'b0;
  logic crc_e = 1'b0;
  logic fec_e = 1'b0;
  logic crc_f = 1'b0;
  logic fec_f = 1'b0;
  logic [3:0] cur = 4'h8;
  rcsr_radio_in_t radio;
  rcsr_ctrl_out_t ctrl;
  logic if_shift, pkt_drop, src_clr, irq;
  int failures = 0;
  int n_tests = 0;
  int n_shift = 0;
  int n_drop = 0;
  int n_clr = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h3a496eed;

  rcsr_top rcsr_top_inst (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .radio_i(radio), .ctrl_o(ctrl), .if_shift_o(if_shift), .pkt_drop_o(pkt_drop),
    .irq_src_clear_o(src_clr), .irq_o(irq)
  );
  rcsr_radio_model rcsr_radio_model_inst (
    .clk_i(clk), .rst_i(rst), .lvl_i(lvl), .pkt_i(pkt), .crc_err_i(crc_e),
    .fec_err_i(fec_e), .busy_i(busy), .radio_o(radio)
  );

  always #5 clk = ~clk;

  // Pulse counters, sampled away from the launching edge
  always @(negedge clk) begin
    n_shift += (if_shift === 1'b1);
    n_drop += (pkt_drop === 1'b1);
    n_clr += (src_clr === 1'b1);
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [2:0] code_of(input logic [3:0] n);
    case (n)
      4'h9: return 3'h1;
      4'ha: return 3'h2;
      4'hb: return 3'h3;
      4'hc: return 3'h5;
      4'hd: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] stat_exp();
    return {16'h0, lvl[0], 2'h0, lvl[3:1], fec_f, crc_f, lvl[6:5], cur >= 4'hb,
      cur == 4'hd, cur >= 4'hc, code_of(cur)};
  endfunction

  function automatic logic res_of(input int s);
    case (s)
      1, 8: return crc_f;
      2: return lvl[3];
      3: return lvl[2];
      6: return lvl[1];
      default: return 1'b0;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic cycle: hold until ack is seen, release at that edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] q, m, r;
    logic [3:0] n;
    logic [3:0] cmds [7];
    int ns, nd, nc;
    cmds = '{4'h9, 4'hb, 4'hc, 4'hd, 4'h3, 4'ha, 4'h8};
    ns = 0;
    nd = 0;
    nc = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_STATUS, q);
    chk("status reset", q, 32'h0);
    rd(32'h50001000, q);
    chk("unmapped", q, 32'h0);
    // Every command, an undefined nibble, random mode settings
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 7; i++) begin
        r = xs();
        m = (p == 0) ? (r | 32'h20) : r;
        lvl <= r[30:24];
        wr(ADDR_MODE, m);
        n = cmds[i];
        ns += (m[5] && n == 4'hc && cur != 4'hc);
        if (n >= 4'h8 && n <= 4'hd) cur = n;
        wr(ADDR_COMMAND, {r[31:8], n, r[3:0]});
        rd(ADDR_MODE, q);
        chk("mode", q, {24'h0, m[7], 1'b0, m[5], lvl[4], 1'b0, m[2], m[1], 1'b0});
        chk("mode ctrl", {ctrl.fifo_msb_first, ctrl.len_msb_first, ctrl.auto_if_en,
          ctrl.fifo_mode, ctrl.test_bit}, {m[7], m[8], m[5], m[1], m[2]});
        rd(ADDR_STATUS, q);
        if (cur < 4'hc) q[4] = 1'b0;
        chk("status", q, stat_exp());
        chk("state", {ctrl.synth_on, ctrl.trx_on, ctrl.trx_dir, ctrl.state_code},
          {cur >= 4'hb, cur >= 4'hc, cur == 4'hd, code_of(cur)});
        chk("if shift", n_shift, ns);
      end
    end
    // Lane 1 alone: length order cleared, low mode bits kept
    sel <= 4'h2;
    wr(ADDR_MODE, 32'h0);
    sel <= 4'hf;
    repeat (2) @(negedge clk);
    chk("sel lanes", {ctrl.fifo_msb_first, ctrl.len_msb_first}, {m[7], 1'b0});
    // Packets with random filters, carrier and check results
    for (int i = 0; i < 12; i++) begin
      r = xs();
      wr(ADDR_MODE, {27'h0, r[4:3], 3'h0});
      lvl <= r[14:8];
      crc_e <= r[6];
      fec_e <= r[7];
      pkt <= 1'b1;
      @(posedge clk);
      pkt <= 1'b0;
      nd += (r[4] & ~r[12]) | (r[3] & r[6]);
      crc_f = r[6];
      fec_f = r[7];
      rd(ADDR_STATUS, q);
      if (cur < 4'hc) q[4] = 1'b0;
      chk("pkt status", q, stat_exp());
      chk("drops", n_drop, nd);
    end
    // Every source code with random busy lines
    for (int s = 0; s < 11; s++) begin
      r = xs();
      busy <= r[10:0];
      lvl <= r[26:20];
      wr(ADDR_IRQ_SELECT, s);
      wr(ADDR_INTERRUPT, {24'h0, r[15], 5'h0, r[16], 1'b0});
      nc += r[15];
      rd(ADDR_INTERRUPT, q);
      chk("irq reg", q, {24'h0, s != 0 && r[s], res_of(s), 2'h0, s[3:0]});
      chk("tx wake", ctrl.tx_wake_after, r[16]);
      chk("src clear", n_clr, nc);
    end
    // Sticky events, mask and write-one-to-clear
    wr(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_IRQ_STATUS, 32'h7);
    wr(ADDR_COMMAND, (cur == 4'h9) ? 32'ha0 : 32'h90);
    rd(ADDR_IRQ_STATUS, q);
    chk("event state", q, 32'h4);
    chk("irq masked", irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h4);
    repeat (2) @(negedge clk);
    chk("irq on", irq, 1'b1);
    wr(ADDR_IRQ_STATUS, 32'h4);
    repeat (2) @(negedge clk);
    chk("irq off", irq, 1'b0);
    @(posedge clk);
    pkt <= 1'b1;
    @(posedge clk);
    pkt <= 1'b0;
    rd(ADDR_IRQ_STATUS, q);
    chk("event pkt", q, 32'h1);
    chk("irq pkt masked", irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(negedge clk);
    chk("irq pkt", irq, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire

// >>> core/rcsr_pkg.sv
// Contract
// [R1] Command upper nibble selects the radio state
// [R2] FIFO bit order: 0 LSB first, 1 MSB
// [R3] Auto-IF shifts LO on each receive entry
// [R4] Carrier filter drops packets without carrier
// [R5] Carrier detect reads input power above threshold
// [R6] CRC filter drops packets failing CRC
// [R7] Length bit order at mode bit 8
// [R8] Chip status reports chip enabled
// [R9] Crystal status reports oscillator running
// [R10] Synth status set after synthesizer command
// [R11] Transceiver active flag and direction bit
// [R12] Three-bit state code per current state
// [R13] FEC and CRC flags refreshed per packet
// [R14] Interrupt state clear pulses and self-clears
// [R15] Transmit wake interrupt before or after final
// [R16] Pending bit shows selected source busy
// [R17] Four-bit interrupt source selection codes
// [R18] Result flag mirrors flag of selected source
// [R19] Undefined command nibble leaves state unchanged
package rcsr_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_COMMAND = 32'h50001004;
  localparam logic [31:0] ADDR_MODE = 32'h50001008;
  localparam logic [31:0] ADDR_STATUS = 32'h50001010;
  localparam logic [31:0] ADDR_INTERRUPT = 32'h50001014;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h5000101c;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h50001040;
  localparam logic [31:0] ADDR_IRQ_SELECT = 32'h50001044;
  // Mode register field positions
  localparam int MODE_FIFO_ORDER = 7;
  localparam int MODE_AUTO_IF = 5;
  localparam int MODE_DROP_NO_CD = 4;
  localparam int MODE_CARRIER = 4;
  localparam int MODE_DROP_CRC = 3;
  localparam int MODE_TEST_BIT = 2;
  localparam int MODE_FIFO_SEL = 1;
  localparam int MODE_LEN_ORDER = 8;
  // Interrupt register field positions
  localparam int INT_CLEAR = 7;
  localparam int INT_PENDING = 7;
  localparam int INT_RESULT = 6;
  localparam int INT_TX_WAKE = 1;
  // Command nibbles
  localparam logic [3:0] CMD_SLEEP = 4'h8;
  localparam logic [3:0] CMD_IDLE = 4'h9;
  localparam logic [3:0] CMD_STANDBY = 4'ha;
  localparam logic [3:0] CMD_SYNTH = 4'hb;
  localparam logic [3:0] CMD_RX = 4'hc;
  localparam logic [3:0] CMD_TX = 4'hd;
  // Reported state codes
  localparam logic [2:0] CODE_SLEEP = 3'h0;
  localparam logic [2:0] CODE_IDLE = 3'h1;
  localparam logic [2:0] CODE_STANDBY = 3'h2;
  localparam logic [2:0] CODE_SYNTH = 3'h3;
  localparam logic [2:0] CODE_TX = 3'h4;
  localparam logic [2:0] CODE_RX = 3'h5;
  // Interrupt source codes
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_WAIT_TRX_DONE = 4'h1;
  localparam logic [3:0] SRC_CSMA = 4'h2;
  localparam logic [3:0] SRC_CCA = 4'h3;
  localparam logic [3:0] SRC_FIFO_MARGIN = 4'h6;
  localparam logic [3:0] SRC_WAKE_RX_CYCLE = 4'h8;
  localparam logic [3:0] SRC_LAST = 4'ha;
  localparam int SRC_COUNT = 11;
  // Sticky event bits: packet received, source done, state changed
  localparam int EV_COUNT = 3;
  localparam int EV_PACKET = 0;
  localparam int EV_SRC_DONE = 1;
  localparam int EV_STATE = 2;
  // Values after reset
  localparam logic [8:0] MODE_RESET = 9'h000;
  localparam logic [3:0] SELECT_RESET = 4'h0;
  localparam logic [2:0] EV_RESET = 3'h0;

  typedef enum logic [2:0] {
    ST_SLEEP, ST_IDLE, ST_STANDBY, ST_SYNTH, ST_RX, ST_TX
  } rcsr_state_t;

  // Inputs from the radio datapath
  typedef struct packed {
    logic chip_enable;
    logic xtal_running;
    logic carrier_above;
    logic pkt_valid;
    logic pkt_crc_err;
    logic pkt_fec_err;
    logic csma_fail;
    logic cca_fail;
    logic fifo_margin;
    logic frame_pending;
    logic [SRC_COUNT-1:0] src_busy;
  } rcsr_radio_in_t;

  // Controls driven to the radio datapath
  typedef struct packed {
    logic fifo_msb_first;
    logic len_msb_first;
    logic auto_if_en;
    logic fifo_mode;
    logic test_bit;
    logic tx_wake_after;
    logic synth_on;
    logic trx_on;
    logic trx_dir;
    logic [2:0] state_code;
  } rcsr_ctrl_out_t;
endpackage

// >>> core/rcsr_top.sv
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rcsr_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire rcsr_pkg::rcsr_radio_in_t radio_i,
  output rcsr_pkg::rcsr_ctrl_out_t ctrl_o,
  output logic if_shift_o,
  output logic pkt_drop_o,
  output logic irq_src_clear_o,
  output logic irq_o
);
  import rcsr_pkg::*;

  rcsr_state_t state;
  rcsr_state_t next_state;
  logic [8:0] mode;
  logic tx_wake_after;
  logic [3:0] src_sel;
  logic [EV_COUNT-1:0] ev_status;
  logic [EV_COUNT-1:0] ev_mask;
  logic [EV_COUNT-1:0] ev_set;
  logic carrier;
  logic chip_on;
  logic xtal_on;
  logic synth_on;
  logic fec_flag;
  logic crc_flag;
  logic pend;
  logic sel_busy;
  logic sel_result;
  logic wr_go;
  logic cmd_wr;
  logic [2:0] cur_code;
  logic [31:0] rd_mux;

  // Code reported for each state
  function automatic logic [2:0] code_of(input rcsr_state_t s);
    case (s)
      ST_SLEEP: code_of = CODE_SLEEP;
      ST_IDLE: code_of = CODE_IDLE;
      ST_STANDBY: code_of = CODE_STANDBY;
      ST_SYNTH: code_of = CODE_SYNTH;
      ST_TX: code_of = CODE_TX;
      ST_RX: code_of = CODE_RX;
      default: code_of = CODE_SLEEP;
    endcase
  endfunction

  // Bus write strobe, taken at the edge where ack is sampled
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign cmd_wr = wr_go && wb_adr_i == ADDR_COMMAND && wb_sel_i[0];
  assign cur_code = code_of(state);

  // One ack per request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Command nibble decode
  always_comb begin
    next_state = state;
    if (cmd_wr) begin
      case (wb_dat_i[7:4])
        CMD_SLEEP: next_state = ST_SLEEP; // [R1]
        CMD_IDLE: next_state = ST_IDLE; // [R1]
        CMD_STANDBY: next_state = ST_STANDBY; // [R1]
        CMD_SYNTH: next_state = ST_SYNTH; // [R1]
        CMD_RX: next_state = ST_RX; // [R1]
        CMD_TX: next_state = ST_TX; // [R1]
        default: next_state = state; // [R19]
      endcase
    end
  end

  // Radio state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  // LO offset pulse on each entry into receive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if_shift_o <= 1'b0;
    end else begin
      if_shift_o <= mode[MODE_AUTO_IF] && state != ST_RX && next_state == ST_RX; // [R3]
    end
  end

  // Synthesizer stays on from its command through receive and transmit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      synth_on <= 1'b0;
    end else begin
      synth_on <= next_state == ST_SYNTH || next_state == ST_RX || next_state == ST_TX; // [R10]
    end
  end

  // Mode register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= MODE_RESET;
    end else if (wr_go && wb_adr_i == ADDR_MODE) begin
      if (wb_sel_i[0]) begin
        mode[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        mode[MODE_LEN_ORDER] <= wb_dat_i[MODE_LEN_ORDER];
      end
    end
  end

  // Interrupt configuration: timing bit and source select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_wake_after <= 1'b0;
      src_sel <= SELECT_RESET;
    end else begin
      if (wr_go && wb_adr_i == ADDR_INTERRUPT && wb_sel_i[0]) begin
        tx_wake_after <= wb_dat_i[INT_TX_WAKE]; // [R15]
      end
      if (wr_go && wb_adr_i == ADDR_IRQ_SELECT && wb_sel_i[0]) begin
        src_sel <= wb_dat_i[3:0]; // [R17]
      end
    end
  end

  // Clear pulse for the interrupt sources, one cycle then back to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_src_clear_o <= 1'b0;
    end else begin
      irq_src_clear_o <= wr_go && wb_adr_i == ADDR_INTERRUPT && wb_sel_i[0]
        && wb_dat_i[INT_CLEAR]; // [R14]
    end
  end

  // Selected source busy and its result flag
  always_comb begin
    sel_busy = 1'b0;
    if (src_sel != SRC_NONE && src_sel <= SRC_LAST) begin
      sel_busy = radio_i.src_busy[src_sel]; // [R16]
    end
    case (src_sel)
      SRC_WAIT_TRX_DONE: sel_result = crc_flag; // [R18]
      SRC_WAKE_RX_CYCLE: sel_result = crc_flag; // [R18]
      SRC_CSMA: sel_result = radio_i.csma_fail; // [R18]
      SRC_CCA: sel_result = radio_i.cca_fail; // [R18]
      SRC_FIFO_MARGIN: sel_result = radio_i.fifo_margin; // [R18]
      default: sel_result = 1'b0;
    endcase
  end

  // Sampled level status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carrier <= 1'b0;
      chip_on <= 1'b0;
      xtal_on <= 1'b0;
      pend <= 1'b0;
    end else begin
      carrier <= radio_i.carrier_above; // [R5]
      chip_on <= radio_i.chip_enable; // [R8]
      xtal_on <= radio_i.xtal_running; // [R9]
      pend <= sel_busy; // [R16]
    end
  end

  // Per-packet FEC and CRC results
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fec_flag <= 1'b0;
      crc_flag <= 1'b0;
    end else if (radio_i.pkt_valid) begin
      fec_flag <= radio_i.pkt_fec_err; // [R13]
      crc_flag <= radio_i.pkt_crc_err; // [R13]
    end
  end

  // Packet filter decision, one pulse per dropped packet
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pkt_drop_o <= 1'b0;
    end else begin
      pkt_drop_o <= radio_i.pkt_valid
        && ((mode[MODE_DROP_NO_CD] && !radio_i.carrier_above) // [R4]
        || (mode[MODE_DROP_CRC] && radio_i.pkt_crc_err)); // [R6]
    end
  end

  // Control outputs to the datapath
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_o <= '0;
    end else begin
      ctrl_o.fifo_msb_first <= mode[MODE_FIFO_ORDER]; // [R2]
      ctrl_o.len_msb_first <= mode[MODE_LEN_ORDER]; // [R7]
      ctrl_o.auto_if_en <= mode[MODE_AUTO_IF];
      ctrl_o.fifo_mode <= mode[MODE_FIFO_SEL];
      ctrl_o.test_bit <= mode[MODE_TEST_BIT];
      ctrl_o.tx_wake_after <= tx_wake_after;
      ctrl_o.synth_on <= synth_on;
      ctrl_o.trx_on <= state == ST_RX || state == ST_TX; // [R11]
      ctrl_o.trx_dir <= state == ST_TX; // [R11]
      ctrl_o.state_code <= cur_code; // [R12]
    end
  end

  // Events feeding the sticky status bits
  assign ev_set[EV_PACKET] = radio_i.pkt_valid;
  assign ev_set[EV_SRC_DONE] = pend && !sel_busy;
  assign ev_set[EV_STATE] = next_state != state;

  // Sticky status, write one to clear, a new event wins over the clear
  genvar gi;
  generate
    for (gi = 0; gi < EV_COUNT; gi++) begin : g_ev
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ev_status[gi] <= EV_RESET[gi];
        end else if (ev_set[gi]) begin
          ev_status[gi] <= 1'b1;
        end else if (wr_go && wb_adr_i == ADDR_IRQ_STATUS && wb_sel_i[0] && wb_dat_i[gi]) begin
          ev_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_mask <= EV_RESET;
    end else if (wr_go && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0]) begin
      ev_mask <= wb_dat_i[EV_COUNT-1:0];
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(ev_status & ev_mask);
    end
  end

  // Read mux, unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      ADDR_MODE: begin
        rd_mux[MODE_FIFO_ORDER] = mode[MODE_FIFO_ORDER];
        rd_mux[MODE_AUTO_IF] = mode[MODE_AUTO_IF];
        rd_mux[MODE_CARRIER] = carrier; // [R5]
        rd_mux[MODE_TEST_BIT] = mode[MODE_TEST_BIT];
        rd_mux[MODE_FIFO_SEL] = mode[MODE_FIFO_SEL];
      end
      ADDR_STATUS: begin
        rd_mux[7:0] = {chip_on, xtal_on, synth_on, state == ST_TX,
          state == ST_RX || state == ST_TX, cur_code}; // [R11]
        rd_mux[15:8] = {radio_i.frame_pending, 2'h0, radio_i.csma_fail,
          radio_i.cca_fail, radio_i.fifo_margin, fec_flag, crc_flag};
      end
      ADDR_INTERRUPT: begin
        rd_mux[INT_PENDING] = pend; // [R16]
        rd_mux[INT_RESULT] = sel_result; // [R18]
        rd_mux[3:0] = src_sel;
      end
      ADDR_IRQ_STATUS: rd_mux[EV_COUNT-1:0] = ev_status;
      ADDR_IRQ_MASK: rd_mux[EV_COUNT-1:0] = ev_mask;
      ADDR_IRQ_SELECT: rd_mux[3:0] = src_sel;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= rd_mux;
    end
  end

  // Checks
  AST_CMD_SLEEP: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    cmd_wr && wb_dat_i[7:4] == CMD_SLEEP |=> state == ST_SLEEP)
    else $error("sleep command not taken");
  AST_CMD_UNDEF: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    cmd_wr && (wb_dat_i[7:4] < CMD_SLEEP || wb_dat_i[7:4] > CMD_TX) |=> $stable(state))
    else $error("undefined command changed state");
  AST_CODE_RX: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    cmd_wr && wb_dat_i[7:4] == CMD_RX |=> ##1 ctrl_o.state_code == CODE_RX)
    else $error("receive code wrong");
  AST_TRX_TX: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    cmd_wr && wb_dat_i[7:4] == CMD_TX |=> ##1 ctrl_o.trx_on && ctrl_o.trx_dir)
    else $error("transmit direction wrong");
  AST_IF_SHIFT: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    cmd_wr && wb_dat_i[7:4] == CMD_RX && state != ST_RX && mode[MODE_AUTO_IF]
    |=> if_shift_o ##1 !if_shift_o)
    else $error("auto-IF shift missing");
  AST_DROP_CD: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    radio_i.pkt_valid && mode[MODE_DROP_NO_CD] && !radio_i.carrier_above |=> pkt_drop_o)
    else $error("no-carrier packet kept");
  AST_NO_FILTER: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    radio_i.pkt_valid && !mode[MODE_DROP_CRC] && !mode[MODE_DROP_NO_CD] |=> !pkt_drop_o)
    else $error("packet dropped with filters off");
  AST_CRC_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    radio_i.pkt_valid |=> crc_flag == $past(radio_i.pkt_crc_err)
    && fec_flag == $past(radio_i.pkt_fec_err))
    else $error("packet flags not refreshed");
  AST_CLEAR_PULSE: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    wr_go && wb_adr_i == ADDR_INTERRUPT && wb_sel_i[0] && wb_dat_i[INT_CLEAR]
    |=> irq_src_clear_o ##1 !irq_src_clear_o)
    else $error("clear pulse wrong");
  AST_PENDING: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    src_sel == SRC_NONE && $stable(src_sel) |=> !pend)
    else $error("pending with no source");
  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_set[EV_PACKET] |=> ev_status[EV_PACKET])
    else $error("event lost");
  AST_ACK_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule
`default_nettype wire
